/* hw/pwt_port_word_transfer.sv */
// Port word transfer: moves port ranges to and from the accumulator.
// Assumes commands come from logic on clk; port inputs come from pins.
//
// Summary of operation
// - Binary read gathers range into accumulator
// - Binary read range at most 32 bits
// - Full 32-bit read keeps sign bit
// - BCD read decodes digits into accumulator
// - BCD read at most eight digits
// - Four ports per BCD digit read
// - Binary write drives accumulator onto range
// - Binary write range at most 32 bits
// - BCD write encodes accumulator onto outputs
// - BCD write at most eight digits
// - Four outputs per BCD digit written
// - Stored format governs all four transfers
// - Format zero passes data unchanged, default
// - Format three swaps halves and bytes
`include "pwt_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pwt_port_word_transfer
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    cmd_valid,
    input  wire pwt_pkg::pwt_cmd_t       cmd,
    input  wire logic [`PWT_WORD_W-1:0]  port_in,
    output var  logic [`PWT_WORD_W-1:0]  port_out,
    output var  pwt_pkg::pwt_rsp_t       rsp,
    output var  logic [1:0]              fmt_cur
);
    import pwt_pkg::*;

    // =================================================
    // Helpers

    // Reorder a word per format; self-inverse
    function automatic logic [`PWT_WORD_W-1:0] fmt_swap
    (
        input logic [`PWT_WORD_W-1:0] w,
        input logic [1:0]             f
    );
        logic [`PWT_WORD_W-1:0] t;
        t = w;
        if (f[0])
            t = {t[15:0], t[31:16]};
        if (f[1])
            t = {t[23:16], t[31:24], t[7:0], t[15:8]};
        return t;
    endfunction : fmt_swap

    // Mask of the low n bits, n up to 32
    function automatic logic [`PWT_WORD_W-1:0] low_mask
    (
        input logic [5:0] n
    );
        logic [`PWT_WORD_W:0] m;
        m = ({{`PWT_WORD_W{1'b0}}, 1'b1} << n) - 33'h1;
        return m[`PWT_WORD_W-1:0];
    endfunction : low_mask

    // Packed BCD to binary, eight digits
    function automatic logic [`PWT_WORD_W-1:0] bcd_to_bin
    (
        input logic [`PWT_WORD_W-1:0] b
    );
        logic [`PWT_WORD_W-1:0] acc;
        acc = 32'h0;
        for (int i = `PWT_MAX_DIGITS - 1; i >= 0; i--)
            acc = 32'((acc * 32'd10) + {28'h0, b[i*4 +: 4]});
        return acc;
    endfunction : bcd_to_bin

    // Binary to packed BCD, eight digits
    function automatic logic [`PWT_WORD_W-1:0] bin_to_bcd
    (
        input logic [`PWT_WORD_W-1:0] v
    );
        logic [`PWT_WORD_W-1:0] r;
        logic [`PWT_WORD_W-1:0] q;
        r = 32'h0;
        q = v;
        for (int i = 0; i < `PWT_MAX_DIGITS; i++)
        begin
            r[i*4 +: 4] = 4'(q % 32'd10);
            q = q / 32'd10;
        end
        return r;
    endfunction : bin_to_bcd

    // =================================================
    // Input synchroniser
    logic [`PWT_WORD_W-1:0] sync1_r;
    logic [`PWT_WORD_W-1:0] sync2_r;
    logic [`PWT_WORD_W-1:0] sync1_nxt;
    logic [`PWT_WORD_W-1:0] sync2_nxt;

    // Next stage values; only stage two feeds the logic
    always_comb
    begin
        sync1_nxt = port_in;
        sync2_nxt = sync1_r;
    end

    // Two flops ahead of any port logic
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync1_r <= 32'h0;
            sync2_r <= 32'h0;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // =================================================
    // Transfer state
    logic [`PWT_WORD_W-1:0] out_r;
    logic [`PWT_WORD_W-1:0] out_nxt;
    pwt_rsp_t               rsp_r;
    pwt_rsp_t               rsp_nxt;
    logic [1:0]             fmt_r;
    logic [1:0]             fmt_nxt;
    logic [`PWT_WORD_W-1:0] out_val;
    logic [`PWT_WORD_W-1:0] out_ins;

    // =================================================
    // Command decode
    logic [5:0]             dec_width;
    logic [5:0]             dec_lo;
    logic [6:0]             dec_end;
    logic                   dec_bad;
    logic                   dec_write;
    logic [`PWT_WORD_W-1:0] dec_mask;
    logic [`PWT_WORD_W-1:0] rd_word;
    logic [`PWT_WORD_W-1:0] rd_field;

    // Span of the range in bits and whether it fits the word
    always_comb
    begin
        dec_width = 6'h0;
        dec_lo    = {1'b0, cmd.start_idx};
        dec_bad   = 1'b0;
        case (cmd.op)
            PWT_OP_BIN_READ, PWT_OP_BIN_WRITE:
            begin
                // Reversed range has no meaning
                if (cmd.end_idx < cmd.start_idx)
                begin
                    dec_bad = 1'b1;
                end
                dec_width = 6'(cmd.end_idx) - dec_lo + 6'h1;
            end
            PWT_OP_BCD_READ, PWT_OP_BCD_WRITE:
            begin
                // Zero digits or more than eight are refused
                if (cmd.digits == 4'h0 ||
                    cmd.digits > 4'(`PWT_MAX_DIGITS))
                begin
                    dec_bad = 1'b1;
                end
                dec_width = {cmd.digits, 2'b00};
            end
            default:
            begin
                dec_width = 6'h0;
            end
        endcase
        // Seven bits so that a wide span cannot wrap
        dec_end = {1'b0, dec_lo} + {1'b0, dec_width};
        if (dec_end > 7'(`PWT_MAX_BITS))
        begin
            dec_bad = 1'b1;
        end
        dec_mask  = low_mask(dec_width) << dec_lo;
        dec_write = (cmd.op == PWT_OP_BIN_WRITE) ||
                    (cmd.op == PWT_OP_BCD_WRITE);
    end

    // Synced port word in the selected order, cut down to the range
    always_comb
    begin
        rd_word  = fmt_swap(sync2_r, fmt_r);
        rd_field = (rd_word & dec_mask) >> dec_lo;
    end

    // =================================================
    // Output word

    // Next outputs: only a write that fits moves them
    always_comb
    begin
        out_val = cmd.acc;
        out_ins = 32'h0;
        out_nxt = out_r;
        if (cmd_valid && dec_write && !dec_bad)
        begin
            // Packed decimal keeps the low digits only
            if (cmd.op == PWT_OP_BCD_WRITE)
            begin
                out_val = bin_to_bcd(cmd.acc);
            end
            // Work in accumulator order, then put the format back
            out_ins = fmt_swap(out_r, fmt_r) & ~dec_mask;
            out_ins = out_ins
                    | ((out_val << dec_lo) & dec_mask);
            out_nxt = fmt_swap(out_ins, fmt_r);
        end
    end

    // Output register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            out_r <= 32'h0;
        end
        else
        begin
            out_r <= out_nxt;
        end
    end

    // =================================================
    // Answer to the interpreter

    // Done on every taken command; acc moves on a good read only
    always_comb
    begin
        rsp_nxt = '{done: 1'b0, err: 1'b0, acc: rsp_r.acc};
        if (cmd_valid)
        begin
            rsp_nxt.done = 1'b1;
            case (cmd.op)
                PWT_OP_BIN_READ:
                begin
                    rsp_nxt.err = dec_bad;
                    // A full 32-bit span keeps bit 31 as the sign
                    if (!dec_bad)
                    begin
                        rsp_nxt.acc = rd_field;
                    end
                end
                PWT_OP_BCD_READ:
                begin
                    rsp_nxt.err = dec_bad;
                    if (!dec_bad)
                    begin
                        rsp_nxt.acc = bcd_to_bin(rd_field);
                    end
                end
                PWT_OP_BIN_WRITE, PWT_OP_BCD_WRITE:
                begin
                    rsp_nxt.err = dec_bad;
                end
                PWT_OP_FORMAT:
                begin
                    rsp_nxt.err = 1'b0;
                end
                default:
                begin
                    rsp_nxt.err = 1'b1;
                end
            endcase
        end
    end

    // Answer register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rsp_r <= '0;
        end
        else
        begin
            rsp_r <= rsp_nxt;
        end
    end

    // =================================================
    // Transfer format

    // Held until the next format select; never refused
    always_comb
    begin
        fmt_nxt = fmt_r;
        if (cmd_valid && cmd.op == PWT_OP_FORMAT)
        begin
            fmt_nxt = cmd.fmt;
        end
    end

    // Format register; plain order out of reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fmt_r <= `PWT_FMT_RESET;
        end
        else
        begin
            fmt_r <= fmt_nxt;
        end
    end

    // =================================================
    // Outputs straight from the registers
    assign port_out = out_r;
    assign rsp      = rsp_r;
    assign fmt_cur  = fmt_r;

endmodule : pwt_port_word_transfer

`default_nettype wire

/* hw/pwt_consts.svh */
// Constants for the port word transfer block.
// Assumes inclusion by bare name from design and bench files.
`ifndef PWT_CONSTS_SVH
`define PWT_CONSTS_SVH

// =====================================================
// Widths and limits
`define PWT_WORD_W      32
`define PWT_IDX_W       5
`define PWT_MAX_BITS    32
`define PWT_MAX_DIGITS  8
`define PWT_DIGIT_BITS  4
`define PWT_ACC_VAR     99

// =====================================================
// Format codes
`define PWT_FMT_PLAIN   2'h0
`define PWT_FMT_HALF    2'h1
`define PWT_FMT_BYTE    2'h2
`define PWT_FMT_BOTH    2'h3
`define PWT_FMT_RESET   2'h0

`endif

/* hw/pwt_pkg.sv */
// Types for the port word transfer block.
// Assumes pwt_consts.svh sits on the include path.
`include "pwt_consts.svh"

package pwt_pkg;

    // =================================================
    // Operation codes
    typedef enum logic [2:0]
    {
        PWT_OP_BIN_READ  = 3'h0,
        PWT_OP_BCD_READ  = 3'h1,
        PWT_OP_BIN_WRITE = 3'h2,
        PWT_OP_BCD_WRITE = 3'h3,
        PWT_OP_FORMAT    = 3'h4
    } pwt_op_t;

    // Command from the program interpreter
    typedef struct packed
    {
        pwt_op_t                  op;
        logic [`PWT_IDX_W-1:0]    start_idx;
        logic [`PWT_IDX_W-1:0]    end_idx;
        logic [3:0]               digits;
        logic [1:0]               fmt;
        logic [`PWT_WORD_W-1:0]   acc;
    } pwt_cmd_t;

    // Answer to the program interpreter
    typedef struct packed
    {
        logic                     done;
        logic                     err;
        logic [`PWT_WORD_W-1:0]   acc;
    } pwt_rsp_t;

endpackage : pwt_pkg

/* test/pwt_sva.sv */
// Checker: port-side assertions for the transfer block.
// Assumes a bind into pwt_port_word_transfer.
`timescale 1ns/1ps
`default_nettype none
module pwt_sva
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire pwt_pkg::pwt_cmd_t cmd,
    input wire logic [31:0] port_in,
    input wire logic [31:0] port_out,
    input wire pwt_pkg::pwt_rsp_t rsp,
    input wire logic [1:0] fmt_cur
);
    import pwt_pkg::*;
    pwt_cmd_t c_r;
    logic v_r;
    // Command taken at the last edge
    always_ff @(posedge clk)
    begin
        c_r <= cmd;
        v_r <= cmd_valid && !sys_rst;
    end
    // Kind of that command
    wire logic rd = v_r && c_r.op inside {PWT_OP_BIN_READ, PWT_OP_BCD_READ};
    wire logic wr = v_r && c_r.op inside {PWT_OP_BIN_WRITE, PWT_OP_BCD_WRITE};
    wire logic bd = v_r && c_r.op inside {PWT_OP_BCD_READ, PWT_OP_BCD_WRITE};
    wire logic bn = v_r && c_r.op inside {PWT_OP_BIN_READ, PWT_OP_BIN_WRITE};
    wire logic fm = v_r && c_r.op == PWT_OP_FORMAT;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ==================================================
    // Answers
    a_done_pulse: assert property (rsp.done == v_r)
        else $error("done out of step");
    a_fmt_taken: assert property
        (fm |-> fmt_cur == c_r.fmt && !rsp.err) else $error("format lost");
    a_fmt_hold: assert property (!fm |-> $stable(fmt_cur))
        else $error("format moved");
    a_bin_range: assert property
        (bn && c_r.end_idx < c_r.start_idx |-> rsp.err) else $error("range");
    a_bcd_limit: assert property (bd && (c_r.digits == 0
        || c_r.digits > 8 || c_r.start_idx + 4 * c_r.digits > 32) |-> rsp.err)
        else $error("digits");
    a_refused_keep: assert property (rsp.err |-> $stable(port_out)
        && $stable(rsp.acc)) else $error("refused but changed");
    a_acc_source: assert property (!$stable(rsp.acc) |-> rd)
        else $error("acc moved");
    a_out_source: assert property (!$stable(port_out) |-> wr)
        else $error("outputs moved");
endmodule : pwt_sva
bind pwt_port_word_transfer pwt_sva i_pwt_sva (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .port_in(port_in),
    .port_out(port_out), .rsp(rsp), .fmt_cur(fmt_cur));
`default_nettype wire

/* test/pwt_host.sv */
// Program interpreter model: one command strobe at a time.
// Assumes the bench calls issue and owns the clock.
`timescale 1ns/1ps
`default_nettype none
module pwt_host
(
    input wire logic clk,
    output var logic cmd_valid,
    output var pwt_pkg::pwt_cmd_t cmd
);
    import pwt_pkg::*;
    // Idle at time zero
    initial cmd_valid = 1'b0;
    initial cmd = '0;
    // Strobe one edge, then scramble the lines
    task automatic issue(input pwt_cmd_t c);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd <= ~c;
    endtask : issue
endmodule : pwt_host
`default_nettype wire

/* test/tb.sv */
// Bench: random commands against a reference model.
// Assumes pwt_host and pwt_sva are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pwt_pkg::*;
    logic clk, sys_rst, cmd_valid, e, bn;
    pwt_cmd_t cmd, c;
    pwt_rsp_t rsp;
    logic [31:0] port_in, port_out, mo, ma, w, o, m, f, r;
    logic [1:0] fmt_cur, mf;
    int seed = 44118;
    int bad_count, compares, t, s, d, p;
    longint v;
    logic [66:0] want_q[$];
    logic [66:0] want;
    pwt_port_word_transfer i_pwt_port_word_transfer (.clk(clk),
        .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .port_in(port_in), .port_out(port_out), .rsp(rsp),
        .fmt_cur(fmt_cur));
    pwt_host i_pwt_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));
    // Word reorder for a format code
    function automatic logic [31:0] sw(logic [31:0] x, logic [1:0] g);
        if (g[0]) x = {x[15:0], x[31:16]};
        if (g[1]) x = {x[23:16], x[31:24], x[7:0], x[15:8]};
        return x;
    endfunction : sw
    task automatic chk(logic [67:0] g, logic [67:0] x);
        compares++;
        if (g !== x)
        begin
            $display("MISMATCH %0t %h %h", $time, g, x);
            bad_count++;
        end
    endtask : chk
    task automatic end_sim;
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Expected outcome of one command
    task automatic model(pwt_cmd_t q);
        w = sw(port_in, mf);
        o = sw(mo, mf);
        s = q.start_idx;
        d = q.digits;
        e = q.op > PWT_OP_FORMAT;
        bn = q.op inside {PWT_OP_BIN_READ, PWT_OP_BIN_WRITE};
        if (bn) e = q.end_idx < q.start_idx;
        m = 32'((64'h1 << (bn ? q.end_idx - s + 1 : 4 * d)) - 1) << s;
        if (!bn && q.op < PWT_OP_FORMAT) e = d == 0 || d > 8 || s + 4 * d > 32;
        r = 0;
        p = 1;
        f = 0;
        v = q.acc;
        for (int k = 0; k < d; k++)
        begin
            r = r + ((w >> (s + 4 * k)) & 15) * p;
            p = p * 10;
            f = f | ((v % 10) << (4 * k));
            v = v / 10;
        end
        f = bn ? q.acc << s : f << s;
        if (!e && q.op == PWT_OP_BIN_READ) ma = (w & m) >> s;
        if (!e && q.op == PWT_OP_BCD_READ) ma = r;
        if (!e && q.op inside {PWT_OP_BIN_WRITE, PWT_OP_BCD_WRITE})
            mo = sw((o & ~m) | (f & m), mf);
        if (q.op == PWT_OP_FORMAT) mf = q.fmt;
        want_q.push_back({e, ma, mo, mf});
    endtask : model
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Reset, then random traffic
    initial
    begin
        sys_rst = 1'b1;
        port_in = '0;
        {mo, ma, mf} = '0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({rsp, port_out, fmt_cur}, '0);
        for (int i = 0; i < 300; i++)
        begin
            @(posedge clk);
            port_in <= $random(seed);
            repeat (3) @(posedge clk);
            v = {$random(seed), $random(seed)};
            c = v[50:0];
            c.op = pwt_op_t'(3'({$random(seed)} % 6));
            c.digits = 4'({$random(seed)} % 10);
            if (i % 8 == 0) {c.start_idx, c.end_idx} = 10'h01f;
            if (c.op == PWT_OP_BCD_WRITE) c.acc = {$random(seed)} % 100000000;
            model(c);
            i_pwt_host.issue(c);
            #1;
            t = 0;
            while (rsp.done !== 1'b1 && t < 4)
            begin
                @(posedge clk);
                #1;
                t++;
            end
            if (t == 4)
            begin
                bad_count++;
                break;
            end
            want = want_q.pop_front();
            chk(rsp.err, want[66]);
            chk(rsp.acc, want[65:34]);
            chk(port_out, want[33:2]);
            chk(fmt_cur, want[1:0]);
        end
        end_sim;
    end
endmodule : tb
`default_nettype wire
